// ### mode_status_pkg.sv
// Package with constants and carrier types for the mode status block.
package mode_status_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] MODE_STATUS_OFFSET = 12'h000;
  localparam logic [11:0] CORE_CTRL_OFFSET = 12'h004;
  localparam logic [11:0] VECTOR_PROBE_OFFSET = 12'h008;

  // ****************************************************************
  // Field layout of the mode status word
  // ****************************************************************
  localparam int PTR_MSB = 15;
  localparam int PTR_LSB = 7;
  localparam int ROM_DIS_BIT = 6;
  localparam int OVERLAY_BIT = 5;
  localparam int ADDR_VIS_BIT = 4;
  localparam int DATA_ROM_BIT = 3;
  localparam int CLK_OFF_BIT = 2;
  localparam int MUL_SAT_BIT = 1;
  localparam int STORE_SAT_BIT = 0;
  localparam logic [8:0] PTR_RESET = 9'h1ff;
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'hff80;
  localparam int SLOT_WORDS = 4;
  localparam int SLOT_SHIFT = 2;
  localparam int PAGE_WORDS = 128;
  localparam logic [15:0] PAGE0_LAST = 16'h007f;

  // ****************************************************************
  // Clock output divider
  // ****************************************************************
  localparam logic [3:0] CLOCK_OUT_HALF_PERIOD = 4'h1;

  typedef struct packed {
    logic [8:0] vectorPagePointer;
    logic romDisableMode;
    logic ramOverlay;
    logic addressVisibility;
    logic romInDataSpace;
    logic clockOutputOff;
    logic multiplySaturate;
    logic storeSaturate;
  } mode_status_s;

  typedef struct packed {
    logic [15:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

endpackage : mode_status_pkg

// ### clock_output_gen.sv
// Divider that makes the clock output pin, parked high when stopped.
`timescale 1ns/100ps
module clock_output_gen
  import mode_status_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clockOutputOff,
  output logic clockOutputPin
);

  logic [3:0] count;
  logic [3:0] next_count;
  logic next_clockOutputPin;

  always_comb begin
    next_count = count;
    next_clockOutputPin = clockOutputPin;
    if (clockOutputOff) begin
      // Parked high so external logic sees a clean stop level.
      next_count = 4'h0; // R14
      next_clockOutputPin = 1'b1; // R14
    end else if (count == CLOCK_OUT_HALF_PERIOD - 4'h1) begin
      next_count = 4'h0;
      next_clockOutputPin = ~clockOutputPin;
    end else begin
      next_count = count + 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      count <= 4'h0;
      clockOutputPin <= 1'b1;
    end else begin
      count <= next_count;
      clockOutputPin <= next_clockOutputPin;
    end
  end

  chk_clock_parked: assert property (@(posedge mclk) disable iff (sys_rst) // R14
    $past(clockOutputOff) |-> clockOutputPin)
    else $error("Clock output not held high while off.");

endmodule : clock_output_gen

// ### vector_relocation_mode_status.sv
// Processor mode status register with relocatable vector table logic.
//
// Contract
// [R1] Every vector slot spans four program words.
// [R2] After device reset all vectors sit at program address ff80.
// [R3] Once the page pointer is loaded, user vectors come from that page.
// [R4] Hardware reset sets the pointer to all ones, fixing reset at ff80.
// [R5] The pointer is a 9-bit field in bits 15 to 7 resetting to 1ff.
// [R6] The software reset instruction leaves the page pointer alone.
// [R7] Bit 6 at 0 maps on-chip ROM into program space, at 1 removes it.
// [R8] Bit 6 loads its pin only at reset; software may change it later.
// [R9] Bit 5 resets to 0; at 1 RAM also maps into program space but page 0.
// [R10] Bit 4 at 0 keeps the address pins on the last bus address.
// [R11] Bit 4 at 1 drives the internal program address onto the pins.
// [R12] With bit 4 set, the exposed vector address pairs with acknowledge.
// [R13] Bit 3 resets to 0; at 1 on-chip ROM is mapped into data space.
// [R14] Bit 2 at 1 stops the clock output pin and holds it high.
// [R15] Bit 1 saturates products before accumulation, only with both modes.
// [R16] Bit 0 saturates accumulator stores after the output shift.
// [R17] Vector address is the pointer above a 7-bit offset from the number.
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/100ps
module vector_relocation_mode_status
  import mode_status_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [15:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic romDisablePin,
  input wire logic softwareReset,
  input wire logic vectorTake,
  input wire logic hardwareResetVector,
  input wire logic [4:0] vectorNumber,
  input wire logic [15:0] programAddress,
  input wire logic [15:0] busAddress,
  input wire logic busAddressValid,
  input wire logic overflowMode,
  input wire logic fractionalMode,
  input wire logic [15:0] memAddress,
  input wire logic memIsProgram,
  output logic [15:0] vectorAddress,
  output logic [15:0] externalAddress,
  output logic interruptAcknowledge,
  output logic romInProgram,
  output logic ramInProgram,
  output logic romInData,
  output logic productSaturateEnable,
  output logic storeSaturateEnable,
  output logic clockOutputPin,
  output mode_status_s modeStatus
);

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic [15:0] vectorSlot(input logic [8:0] page,
      input logic [4:0] num);
    // Four words per slot leave room for a delayed branch.
    return {page, num, 2'b00}; // R1 R17
  endfunction : vectorSlot

  function automatic mode_status_s unpackMode(input logic [15:0] w);
    mode_status_s m;
    m.vectorPagePointer = w[PTR_MSB:PTR_LSB];
    m.romDisableMode = w[ROM_DIS_BIT];
    m.ramOverlay = w[OVERLAY_BIT];
    m.addressVisibility = w[ADDR_VIS_BIT];
    m.romInDataSpace = w[DATA_ROM_BIT];
    m.clockOutputOff = w[CLK_OFF_BIT];
    m.multiplySaturate = w[MUL_SAT_BIT];
    m.storeSaturate = w[STORE_SAT_BIT];
    return m;
  endfunction : unpackMode

  // ****************************************************************
  // Register state
  // ****************************************************************
  mode_status_s next_modeStatus;
  logic resetSeen;
  logic next_resetSeen;
  logic [15:0] lastBusAddress;
  logic [15:0] next_lastBusAddress;
  logic [15:0] next_vectorAddress;
  logic next_interruptAcknowledge;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic accessPhase;
  logic writeMode;

  assign accessPhase = psel & penable;
  assign writeMode = accessPhase & pwrite & (paddr[11:0] == MODE_STATUS_OFFSET)
    & (paddr[15:12] == 4'h0);
  assign pready = 1'b1;

  always_comb begin
    next_modeStatus = modeStatus;
    next_resetSeen = 1'b1;
    if (!resetSeen) begin
      // Strap is caught on the first clock after reset release.
      next_modeStatus.romDisableMode = romDisablePin; // R8
    end else if (writeMode) begin
      next_modeStatus = unpackMode(pwdata[15:0]); // R8
    end
    // The software reset instruction is ignored here on purpose. R6
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      modeStatus <= '{vectorPagePointer: PTR_RESET, default: 1'b0}; // R4 R5
      resetSeen <= 1'b0;
    end else begin
      modeStatus <= next_modeStatus;
      resetSeen <= next_resetSeen;
    end
  end

  // ****************************************************************
  // APB read path
  // ****************************************************************
  always_comb begin
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (psel && !penable) begin
      next_prdata = 32'h0000_0000;
      if (paddr[15:12] != 4'h0) begin
        next_pslverr = 1'b1;
      end else begin
        case (paddr[11:0])
          MODE_STATUS_OFFSET: next_prdata = {16'h0000, modeStatus};
          CORE_CTRL_OFFSET: next_prdata = {30'h0, overflowMode,
            fractionalMode};
          VECTOR_PROBE_OFFSET: next_prdata = {16'h0000, vectorAddress};
          default: next_pslverr = 1'b1;
        endcase
      end
    end else if (accessPhase) begin
      next_pslverr = pslverr;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ****************************************************************
  // Vector fetch and address visibility
  // ****************************************************************
  always_comb begin
    next_vectorAddress = vectorAddress;
    next_interruptAcknowledge = 1'b0;
    next_lastBusAddress = lastBusAddress;
    if (busAddressValid) begin
      next_lastBusAddress = busAddress;
    end
    if (vectorTake) begin
      next_interruptAcknowledge = 1'b1; // R12
      if (hardwareResetVector) begin
        next_vectorAddress = RESET_VECTOR_ADDR; // R2 R4
      end else begin
        next_vectorAddress = vectorSlot(modeStatus.vectorPagePointer,
          vectorNumber); // R3 R17
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      vectorAddress <= RESET_VECTOR_ADDR; // R2
      interruptAcknowledge <= 1'b0;
      lastBusAddress <= 16'h0000;
    end else begin
      vectorAddress <= next_vectorAddress;
      interruptAcknowledge <= next_interruptAcknowledge;
      lastBusAddress <= next_lastBusAddress;
    end
  end

  // Control and data lines are untouched; only the address pins differ.
  always_comb begin
    if (modeStatus.addressVisibility) begin
      externalAddress = interruptAcknowledge ? vectorAddress
        : programAddress; // R11 R12
    end else begin
      externalAddress = lastBusAddress; // R10
    end
  end

  // ****************************************************************
  // Memory map steering and saturation enables
  // ****************************************************************
  assign romInProgram = memIsProgram & ~modeStatus.romDisableMode; // R7
  assign ramInProgram = memIsProgram & modeStatus.ramOverlay
    & (memAddress > PAGE0_LAST); // R9
  assign romInData = ~memIsProgram & modeStatus.romInDataSpace; // R13
  assign productSaturateEnable = modeStatus.multiplySaturate
    & overflowMode & fractionalMode; // R15
  assign storeSaturateEnable = modeStatus.storeSaturate; // R16

  clock_output_gen clkGen (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clockOutputOff(modeStatus.clockOutputOff),
    .clockOutputPin(clockOutputPin)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_reset_pointer: assert property (@(posedge mclk) // R4
    $past(sys_rst) && !sys_rst |->
    modeStatus.vectorPagePointer == PTR_RESET)
    else $error("Page pointer not all ones after reset.");

  chk_hw_vector: assert property (@(posedge mclk) disable iff (sys_rst) // R2
    vectorTake && hardwareResetVector |=> vectorAddress == RESET_VECTOR_ADDR)
    else $error("Hardware reset vector not at ff80.");

  chk_user_vector: assert property (@(posedge mclk) disable iff (sys_rst) // R3
    vectorTake && !hardwareResetVector |=>
    vectorAddress == {$past(modeStatus.vectorPagePointer),
    $past(vectorNumber), 2'b00})
    else $error("User vector not on the selected page.");

  chk_slot_align: assert property (@(posedge mclk) disable iff (sys_rst) // R1
    interruptAcknowledge |-> vectorAddress[1:0] == 2'b00)
    else $error("Vector slot not four-word aligned.");

  chk_swreset_keep: assert property (@(posedge mclk) disable iff (sys_rst) // R6
    softwareReset && !writeMode && resetSeen |=> $stable(modeStatus))
    else $error("Software reset altered the mode status.");

  chk_strap_load: assert property (@(posedge mclk) disable iff (sys_rst) // R8
    !resetSeen |=> modeStatus.romDisableMode == $past(romDisablePin))
    else $error("Strap not loaded after reset.");

  chk_vis_off: assert property (@(posedge mclk) disable iff (sys_rst) // R10
    !modeStatus.addressVisibility && !busAddressValid |=>
    !modeStatus.addressVisibility |-> $stable(externalAddress))
    else $error("Address pins moved with visibility off.");

  chk_vis_on: assert property (@(posedge mclk) disable iff (sys_rst) // R11
    modeStatus.addressVisibility && !interruptAcknowledge |->
    externalAddress == programAddress)
    else $error("Program address not visible.");

  chk_overlay_page0: assert property (@(posedge mclk) // R9
    memAddress <= PAGE0_LAST |-> !ramInProgram)
    else $error("Data page 0 overlaid into program space.");

  chk_mul_sat: assert property (@(posedge mclk) // R15
    productSaturateEnable |-> overflowMode && fractionalMode)
    else $error("Product saturation without overflow and fraction.");

  chk_write_lands: assert property (@(posedge mclk) disable iff (sys_rst) // R5
    writeMode && resetSeen |=> modeStatus == $past(pwdata[15:0]))
    else $error("Mode status write did not land.");

  chk_mode_hold: assert property (@(posedge mclk) disable iff (sys_rst) // R8
    resetSeen && !writeMode |=> $stable(modeStatus))
    else $error("Mode status changed without a write.");

  chk_ack_pulse: assert property (@(posedge mclk) disable iff (sys_rst) // R12
    vectorTake |=> interruptAcknowledge)
    else $error("Acknowledge missing after a vector take.");

  chk_ack_pins: assert property (@(posedge mclk) disable iff (sys_rst) // R12
    modeStatus.addressVisibility && interruptAcknowledge |->
    externalAddress == vectorAddress)
    else $error("Vector address not shown with acknowledge.");

  chk_rom_program: assert property (@(posedge mclk) disable iff (sys_rst) // R7
    memIsProgram |-> romInProgram == !modeStatus.romDisableMode)
    else $error("Program ROM mapping disagrees with bit 6.");

  chk_data_rom: assert property (@(posedge mclk) disable iff (sys_rst) // R13
    memIsProgram || !modeStatus.romInDataSpace |-> !romInData)
    else $error("ROM shown in data space while unmapped.");

  chk_store_sat: assert property (@(posedge mclk) disable iff (sys_rst) // R16
    storeSaturateEnable == modeStatus.storeSaturate)
    else $error("Store saturation does not follow bit 0.");

  chk_unmapped_err: assert property (@(posedge mclk) // R5
    disable iff (sys_rst)
    psel && !penable && paddr[11:0] > VECTOR_PROBE_OFFSET |=> pslverr)
    else $error("Unmapped access not flagged.");

  cov_write_mode: cover property (@(posedge mclk) writeMode);
  cov_user_vector: cover property (@(posedge mclk)
    vectorTake && !hardwareResetVector
    && modeStatus.vectorPagePointer != PTR_RESET);
  cov_visible_ack: cover property (@(posedge mclk)
    interruptAcknowledge && modeStatus.addressVisibility);
  cov_hw_vector: cover property (@(posedge mclk)
    vectorTake && hardwareResetVector);
  cov_page0_overlay: cover property (@(posedge mclk)
    memIsProgram && modeStatus.ramOverlay && memAddress <= PAGE0_LAST);

endmodule : vector_relocation_mode_status

// ### core_model.sv
// Core sequencer stand-in that issues vector requests to the block.
`timescale 1ns/100ps
module core_model (
  input wire logic mclk,
  input wire logic go,
  input wire logic hw,
  input wire logic [4:0] num,
  output logic vectorTake,
  output logic hardwareResetVector,
  output logic [4:0] vectorNumber
);
  // Between requests the qualifiers flip every cycle, so the block can
  // never lean on a stale number left over from the last request.
  always @(posedge mclk) begin
    vectorTake <= go;
    hardwareResetVector <= go ? hw : ~hardwareResetVector;
    vectorNumber <= go ? num : ~vectorNumber;
  end
endmodule : core_model

// ### vector_relocation_mode_status_tb.sv
// Self-checking bench for the mode status register block.
`timescale 1ns/100ps
module vector_relocation_mode_status_tb;
  import mode_status_pkg::*;
  localparam logic [15:0] MS = {4'h0, MODE_STATUS_OFFSET};
  localparam logic [15:0] CC = {4'h0, CORE_CTRL_OFFSET};
  logic mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic romDisablePin = 1, softwareReset = 0, busAddressValid = 0;
  logic overflowMode = 0, fractionalMode = 0, memIsProgram = 0;
  logic go = 0, hw = 0, a, visOn = 0;
  logic [15:0] ve;
  logic [15:0] paddr = 0, programAddress = 0, busAddress = 0;
  logic [15:0] memAddress = 0, vectorAddress, externalAddress, ms, ba;
  logic [31:0] pwdata = 0, prdata;
  logic [4:0] num = 0, vectorNumber;
  logic pready, pslverr, vectorTake, hardwareResetVector;
  logic interruptAcknowledge, romInProgram, ramInProgram, romInData;
  logic productSaturateEnable, storeSaturateEnable, clockOutputPin;
  mode_status_s modeStatus;
  logic [8:0] ptr;
  logic [32:0] rdQ[$];
  logic [15:0] vecQ[$];
  int n_fail = 0, check_count = 0, seed = 46, i;

  always #4 mclk = ~mclk;

  core_model u_core_model (.mclk, .go, .hw, .num, .vectorTake,
    .hardwareResetVector, .vectorNumber);
  vector_relocation_mode_status u_vector_relocation_mode_status (
    .mclk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .romDisablePin, .softwareReset,
    .vectorTake, .hardwareResetVector, .vectorNumber, .programAddress,
    .busAddress, .busAddressValid, .overflowMode, .fractionalMode,
    .memAddress, .memIsProgram, .vectorAddress, .externalAddress,
    .interruptAcknowledge, .romInProgram, .ramInProgram, .romInData,
    .productSaturateEnable, .storeSaturateEnable, .clockOutputPin,
    .modeStatus);

  // ****************************************************************
  // Drivers and comparisons
  // ****************************************************************
  task cmp_word(input string w, input logic [32:0] e, input logic [32:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask : cmp_word

  task cmp_bit(input string w, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", w, e, g);
    end
  endtask : cmp_bit

  task apb(input logic w, input logic [15:0] ad, input logic [31:0] d,
           input logic [32:0] e);
    if (!w) rdQ.push_back(e);
    @(posedge mclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask : apb

  task vec(input logic h, input logic [4:0] n, input logic [15:0] e);
    vecQ.push_back(e);
    @(posedge mclk);
    go <= 1;
    hw <= h;
    num <= n;
    @(posedge mclk);
    go <= 0;
    repeat (3) @(posedge mclk);
  endtask : vec

  // Reads and vectors are judged at the edge where the answer stands.
  always @(posedge mclk) begin
    if (psel && penable && pready && !pwrite)
      cmp_word("read", rdQ.pop_front(), {pslverr, prdata});
    if (interruptAcknowledge === 1'b1) begin
      ve = vecQ.pop_front();
      cmp_word("vector", {17'h0, ve}, {17'h0, vectorAddress});
      if (visOn)
        cmp_word("ack_pins", {17'h0, ve}, {17'h0, externalAddress});
    end
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  initial begin
    #(4000 * 8);
    n_fail++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge mclk);
    sys_rst <= 0;
    repeat (2) @(posedge mclk);
    apb(0, MS, 0, {1'b0, 32'h0000ffc0});
    vec(0, 5'h03, RESET_VECTOR_ADDR | 16'h000c);
    vec(0, 5'h1f, RESET_VECTOR_ADDR | 16'h007c);
    vec(1, 5'h05, RESET_VECTOR_ADDR);
    ptr = 9'($random(seed));
    apb(1, MS, {16'h0, ptr, 7'h00}, 0);
    apb(0, MS, 0, {17'h0, ptr, 7'h00});
    vec(0, 5'h1f, {ptr, 7'h7c});
    vec(1, 5'h02, RESET_VECTOR_ADDR);
    @(posedge mclk);
    softwareReset <= 1;
    @(posedge mclk);
    softwareReset <= 0;
    apb(0, MS, 0, {17'h0, ptr, 7'h00});
    for (i = 0; i < 8; i++) begin
      ms = {ptr, 7'($random(seed))};
      ms[1] = i[2];
      ms[2] = i[0];
      ms[4] = i[1];
      ba = 16'($random(seed));
      apb(1, MS, {16'h0, ms}, 0);
      memIsProgram <= 1;
      memAddress <= 16'hff80;
      overflowMode <= i[0];
      fractionalMode <= i[1];
      busAddress <= ba;
      busAddressValid <= 1;
      @(posedge mclk);
      cmp_bit("rom_prog", !ms[6], romInProgram);
      cmp_bit("mul_sat", ms[1] & i[0] & i[1], productSaturateEnable);
      cmp_bit("store_sat", ms[0], storeSaturateEnable);
      memAddress <= 16'h1000;
      busAddressValid <= 0;
      busAddress <= ~ba;
      programAddress <= 16'($random(seed));
      @(posedge mclk);
      cmp_bit("ram_prog", ms[5], ramInProgram);
      a = clockOutputPin;
      memAddress <= 16'h007f;
      @(posedge mclk);
      cmp_bit("ram_page0", 1'b0, ramInProgram);
      cmp_word("ext_addr", {17'h0, ms[4] ? programAddress : ba},
               {17'h0, externalAddress});
      cmp_bit("clk_pin", ms[2] ? 1'b1 : ~a, clockOutputPin);
      memIsProgram <= 0;
      memAddress <= 16'hf000;
      @(posedge mclk);
      cmp_bit("rom_data", ms[3], romInData);
      apb(0, MS, 0, {17'h0, ms});
    end
    apb(0, 16'h000c, 0, {1'b1, 32'h0});
    apb(1, 16'h000c, 32'hffff, 0);
    apb(1, CC, 32'h0000ffff, 0);
    apb(0, CC, 0, {1'b0, 32'h3});
    visOn = ms[4];
    vec(0, 5'h0a, {ptr, 5'h0a, 2'b00});
    apb(0, {4'h0, VECTOR_PROBE_OFFSET}, 0, {17'h0, ptr, 7'h28});
    apb(0, MS, 0, {17'h0, ms});
    repeat (3) @(posedge mclk);
    give_verdict();
  end
endmodule : vector_relocation_mode_status_tb
